// [logic/ghu_group_update.sv]
// Purpose: Records register writes into groups and applies them frame-synchronously
// Assumes: Register port and frame timing strobes synchronous to mclk
// Notes:   While recording is high the outer register file must not commit writes

// Contract
// - Critical frame parameters are captured once per frame at the latch point.
// - A launched group is fully written to targets before the next latch point.
// - A 1536-byte buffer is shared by up to six programmable groups.
// - Group start is its 7-bit start register followed by four zero bits.
// - Default starts give groups 0-3 128 bytes, group 4 256, group 5 the rest.
// - The last two groups hold embedded line lists, never ordinary recordings.
// - Update clock is gated in long vertical blanking unless always-on is set; the code also keeps it on while busy or recording.
// - Command 0 with a group number starts recording into that group.
// - Command 1 with the same group number ends recording.
// - Command 0xA launches the group before the next latch point.
// - Command register is write-only; only codes 0,1,A,E and groups 0-3 valid.
// - Combined launch applies all selected groups in frame, now or line blanking.
// - Auto switching cycles groups, holding each for its programmed frame count.
// - Alternation repeats group 0 and the second group until soft reset.
// - Switch control holds repeat, context switch and switch-back group; reset 0x01.
// - Sync group register gives a frame-sync enable and its first group.
module ghu_group_update (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        clk_always_on,
    input  wire logic        soft_reset,
    input  wire logic        frame_latch,
    input  wire logic        hblank,
    input  wire logic        vblank,
    input  wire logic        long_vblank,
    input  wire logic        fsin_pulse,
    output logic [7:0]       reg_rdata,
    output logic             tgt_wr,
    output logic [15:0]      tgt_addr,
    output logic [7:0]       tgt_data,
    output logic             gw_clk_en,
    output logic             group_busy,
    output logic             recording
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]          start_r [0:4];
    logic [7:0]          start_nxt [0:4];
    logic [7:0]          per_r [0:3];
    logic [7:0]          per_nxt [0:3];
    logic [8:0]          cnt_r [0:3];
    logic [8:0]          cnt_nxt [0:3];
    logic [7:0]          fsin_r, fsin_nxt;
    logic [7:0]          swc_r, swc_nxt;
    logic                rec_on_r, rec_on_nxt;
    logic [1:0]          rec_grp_r, rec_grp_nxt;
    logic [3:0]          pend_r, pend_nxt;
    ghu_pkg::ghu_timing_t tm_r, tm_nxt;
    ghu_pkg::ghu_state_t  st_r, st_nxt;
    logic [8:0]          ptr_r, ptr_nxt;
    logic [8:0]          end_r, end_nxt;
    logic                auto_on_r, auto_on_nxt;
    logic [1:0]          cur_r, cur_nxt;
    logic [7:0]          rdata_r, rdata_nxt;
    logic                twr_r, twr_nxt;
    logic [15:0]         taddr_r, taddr_nxt;
    logic [7:0]          tdata_r, tdata_nxt;
    logic                clken_r, clken_nxt;
    logic                busy_r, busy_nxt;

    logic                fc_clear;
    logic                fc_done;
    logic                go;
    logic                ctl_hit;
    logic [3:0]          cmd_code;
    logic [3:0]          cmd_id;
    logic [1:0]          pick;
    logic [1:0]          nxt_grp;
    logic [8:0]          rec_base;
    logic [8:0]          rec_cap;

    ghu_buf_if bus ();

    ghu_buffer u_buf (
        .mclk (mclk),
        .bus  (bus.mem)
    );

    ghu_frame_cnt u_fcnt (
        .mclk   (mclk),
        .reset  (reset),
        .clear  (fc_clear),
        .tick   (frame_latch && auto_on_r),
        .period (per_r[cur_r]),
        .done   (fc_done)
    );

    // ------------------------------------------------------------
    // Group geometry
    // ------------------------------------------------------------
    // start word from start address
    function automatic logic [8:0] word_of(input logic [7:0] s);
        word_of = {s[6:0], 2'b00};
    endfunction

    // region ends at next start or buffer end
    function automatic logic [8:0] cap_of(input logic [8:0] b, input logic [8:0] e);
        logic [8:0] ec;
        ec = (e > ghu_pkg::BUF_END_W) ? ghu_pkg::BUF_END_W : e;
        cap_of = (ec > b) ? (ec - b) : 9'h000;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            start_nxt[i] = start_r[i];
        end
        for (int i = 0; i < ghu_pkg::REC_GROUPS; i++) begin
            per_nxt[i] = per_r[i];
            cnt_nxt[i] = cnt_r[i];
        end
        fsin_nxt    = fsin_r;
        swc_nxt     = swc_r;
        rec_on_nxt  = rec_on_r;
        rec_grp_nxt = rec_grp_r;
        pend_nxt    = pend_r;
        tm_nxt      = tm_r;
        st_nxt      = st_r;
        ptr_nxt     = ptr_r;
        end_nxt     = end_r;
        auto_on_nxt = auto_on_r;
        cur_nxt     = cur_r;
        rdata_nxt   = 8'h00;
        twr_nxt     = 1'b0;
        taddr_nxt   = taddr_r;
        tdata_nxt   = tdata_r;
        fc_clear    = 1'b0;
        bus.wr      = 1'b0;
        bus.waddr   = 9'h000;
        bus.wdata   = 24'h000000;
        bus.raddr   = ptr_r;
        ctl_hit     = reg_addr[15:4] == ghu_pkg::ADDR_CTL_PAGE;
        cmd_code    = reg_wdata[7:4];
        cmd_id      = reg_wdata[3:0];
        pick        = 2'd0;
        nxt_grp     = (cur_r == 2'd0) ? swc_r[1:0] : 2'd0;
        rec_base    = word_of(start_r[rec_grp_r]);
        rec_cap     = cap_of(rec_base, word_of(start_r[rec_grp_r + 3'd1]));

        // launch timing gate, frame launch waits for blanking before latch
        case (tm_r)
            ghu_pkg::GHU_TM_NOW:    go = 1'b1;
            ghu_pkg::GHU_TM_HBLANK: go = hblank;
            default:                go = vblank;
        endcase

        for (int i = ghu_pkg::REC_GROUPS - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                pick = 2'(i);
            end
        end

        // apply engine walks the group's entries
        case (st_r)
            ghu_pkg::GHU_ST_IDLE: begin
                if (pend_r != 4'h0 && go) begin
                    pend_nxt[pick] = 1'b0;
                    ptr_nxt        = word_of(start_r[pick]);
                    end_nxt        = word_of(start_r[pick]) + cnt_r[pick];
                    if (cnt_r[pick] != 9'h000) begin
                        st_nxt = ghu_pkg::GHU_ST_READ;
                    end
                end
            end
            ghu_pkg::GHU_ST_READ: begin
                st_nxt = ghu_pkg::GHU_ST_WRITE;
            end
            ghu_pkg::GHU_ST_WRITE: begin
                twr_nxt   = 1'b1;
                taddr_nxt = bus.rdata[23:8];
                tdata_nxt = bus.rdata[7:0];
                ptr_nxt   = ptr_r + 9'h001;
                st_nxt    = (ptr_r + 9'h001 == end_r) ? ghu_pkg::GHU_ST_IDLE
                                                      : ghu_pkg::GHU_ST_READ;
            end
            default: begin
                st_nxt = ghu_pkg::GHU_ST_IDLE;
            end
        endcase

        // alternate between group 0 and the switch-back group
        if (fc_done) begin
            cur_nxt           = nxt_grp;
            pend_nxt[nxt_grp] = 1'b1;
            tm_nxt            = ghu_pkg::GHU_TM_FRAME;
        end

        // frame-sync input restarts at its start group
        if (fsin_pulse && fsin_r[ghu_pkg::FSIN_EN_BIT]) begin
            pend_nxt[fsin_r[1:0]] = 1'b1;
            tm_nxt                = ghu_pkg::GHU_TM_FRAME;
            if (auto_on_r) begin
                cur_nxt  = fsin_r[1:0];
                fc_clear = 1'b1;
            end
        end

        if (reg_wr && !ctl_hit && rec_on_r) begin
            // capture write as an entry; a full region drops it
            if (cnt_r[rec_grp_r] < rec_cap) begin
                bus.wr                 = 1'b1;
                bus.waddr              = rec_base + cnt_r[rec_grp_r];
                bus.wdata              = {reg_addr, reg_wdata};
                cnt_nxt[rec_grp_r]     = cnt_r[rec_grp_r] + 9'h001;
            end
        end else if (reg_wr && ctl_hit) begin
            case (reg_addr)
                ghu_pkg::ADDR_GRP0_START: start_nxt[0] = reg_wdata;
                ghu_pkg::ADDR_GRP1_START: start_nxt[1] = reg_wdata;
                ghu_pkg::ADDR_GRP2_START: start_nxt[2] = reg_wdata;
                ghu_pkg::ADDR_GRP3_START: start_nxt[3] = reg_wdata;
                ghu_pkg::ADDR_EMB_START:  start_nxt[4] = reg_wdata;
                ghu_pkg::ADDR_FSIN_GRP:   fsin_nxt     = reg_wdata;
                ghu_pkg::ADDR_GRP0_PER:   per_nxt[0]   = reg_wdata;
                ghu_pkg::ADDR_GRP1_PER:   per_nxt[1]   = reg_wdata;
                ghu_pkg::ADDR_GRP2_PER:   per_nxt[2]   = reg_wdata;
                ghu_pkg::ADDR_GRP3_PER:   per_nxt[3]   = reg_wdata;
                ghu_pkg::ADDR_SW_CTRL:    swc_nxt      = reg_wdata;
                ghu_pkg::ADDR_CMB_LAUNCH: begin
                    if (cmd_code == ghu_pkg::CMB_FRAME) begin
                        pend_nxt = pend_nxt | cmd_id;
                        tm_nxt   = ghu_pkg::GHU_TM_FRAME;
                    end else if (cmd_code == ghu_pkg::CMB_NOW) begin
                        pend_nxt = pend_nxt | cmd_id;
                        tm_nxt   = ghu_pkg::GHU_TM_NOW;
                    end else if (cmd_code == ghu_pkg::CMB_HBLANK) begin
                        pend_nxt = pend_nxt | cmd_id;
                        tm_nxt   = ghu_pkg::GHU_TM_HBLANK;
                    end
                end
                // reserved ids and codes fall through unused
                ghu_pkg::ADDR_GRP_CMD: begin
                    // ids 4 and 5 never accepted here
                    if (cmd_id < 4'(ghu_pkg::REC_GROUPS)) begin
                        case (cmd_code)
                            ghu_pkg::CMD_REC_START: begin
                                rec_on_nxt            = 1'b1;
                                rec_grp_nxt           = cmd_id[1:0];
                                cnt_nxt[cmd_id[1:0]]  = 9'h000;
                            end
                            ghu_pkg::CMD_REC_END: begin
                                if (rec_on_r && rec_grp_r == cmd_id[1:0]) begin
                                    rec_on_nxt = 1'b0;
                                end
                            end
                            ghu_pkg::CMD_LAUNCH: begin
                                pend_nxt[cmd_id[1:0]] = 1'b1;
                                tm_nxt                = ghu_pkg::GHU_TM_FRAME;
                                if (cmd_id == 4'h0 &&
                                    swc_r[ghu_pkg::SW_REPEAT_BIT:ghu_pkg::SW_CTX_BIT]
                                        == ghu_pkg::SW_AUTO_ON) begin
                                    auto_on_nxt = 1'b1;
                                    cur_nxt     = 2'd0;
                                    fc_clear    = 1'b1;
                                end
                            end
                            ghu_pkg::CMD_FAST: begin
                                pend_nxt[cmd_id[1:0]] = 1'b1;
                                tm_nxt                = ghu_pkg::GHU_TM_NOW;
                            end
                            default: begin
                                rec_on_nxt = rec_on_r;
                            end
                        endcase
                    end
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end

        // readback of writable registers, write-only read zero
        if (reg_rd) begin
            case (reg_addr)
                ghu_pkg::ADDR_GRP0_START: rdata_nxt = start_r[0];
                ghu_pkg::ADDR_GRP1_START: rdata_nxt = start_r[1];
                ghu_pkg::ADDR_GRP2_START: rdata_nxt = start_r[2];
                ghu_pkg::ADDR_GRP3_START: rdata_nxt = start_r[3];
                ghu_pkg::ADDR_EMB_START:  rdata_nxt = start_r[4];
                ghu_pkg::ADDR_FSIN_GRP:   rdata_nxt = fsin_r;
                ghu_pkg::ADDR_GRP0_PER:   rdata_nxt = per_r[0];
                ghu_pkg::ADDR_GRP1_PER:   rdata_nxt = per_r[1];
                ghu_pkg::ADDR_GRP2_PER:   rdata_nxt = per_r[2];
                ghu_pkg::ADDR_GRP3_PER:   rdata_nxt = per_r[3];
                ghu_pkg::ADDR_SW_CTRL:    rdata_nxt = swc_r;
                default:                  rdata_nxt = 8'h00;
            endcase
        end

        // soft reset stops alternation and pending work
        if (soft_reset) begin
            auto_on_nxt = 1'b0;
            rec_on_nxt  = 1'b0;
            pend_nxt    = 4'h0;
            st_nxt      = ghu_pkg::GHU_ST_IDLE;
            fc_clear    = 1'b1;
        end

        busy_nxt  = (st_nxt != ghu_pkg::GHU_ST_IDLE) || (pend_nxt != 4'h0);
        clken_nxt = clk_always_on || !long_vblank || busy_nxt || rec_on_nxt;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            start_r[0] <= ghu_pkg::RST_GRP0_START;
            start_r[1] <= ghu_pkg::RST_GRP1_START;
            start_r[2] <= ghu_pkg::RST_GRP2_START;
            start_r[3] <= ghu_pkg::RST_GRP3_START;
            start_r[4] <= ghu_pkg::RST_EMB_START;
            for (int i = 0; i < ghu_pkg::REC_GROUPS; i++) begin
                per_r[i] <= ghu_pkg::RST_PERIOD;
                cnt_r[i] <= 9'h000;
            end
            fsin_r    <= ghu_pkg::RST_FSIN_GRP;
            swc_r     <= ghu_pkg::RST_SW_CTRL;
            rec_on_r  <= 1'b0;
            rec_grp_r <= 2'd0;
            pend_r    <= 4'h0;
            tm_r      <= ghu_pkg::GHU_TM_FRAME;
            st_r      <= ghu_pkg::GHU_ST_IDLE;
            ptr_r     <= 9'h000;
            end_r     <= 9'h000;
            auto_on_r <= 1'b0;
            cur_r     <= 2'd0;
            rdata_r   <= 8'h00;
            twr_r     <= 1'b0;
            taddr_r   <= 16'h0000;
            tdata_r   <= 8'h00;
            clken_r   <= 1'b1;
            busy_r    <= 1'b0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                start_r[i] <= start_nxt[i];
            end
            for (int i = 0; i < ghu_pkg::REC_GROUPS; i++) begin
                per_r[i] <= per_nxt[i];
                cnt_r[i] <= cnt_nxt[i];
            end
            fsin_r    <= fsin_nxt;
            swc_r     <= swc_nxt;
            rec_on_r  <= rec_on_nxt;
            rec_grp_r <= rec_grp_nxt;
            pend_r    <= pend_nxt;
            tm_r      <= tm_nxt;
            st_r      <= st_nxt;
            ptr_r     <= ptr_nxt;
            end_r     <= end_nxt;
            auto_on_r <= auto_on_nxt;
            cur_r     <= cur_nxt;
            rdata_r   <= rdata_nxt;
            twr_r     <= twr_nxt;
            taddr_r   <= taddr_nxt;
            tdata_r   <= tdata_nxt;
            clken_r   <= clken_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // targets commit to frame timing at the latch point outside
    assign tgt_wr     = twr_r;
    assign tgt_addr   = taddr_r;
    assign tgt_data   = tdata_r;
    assign reg_rdata  = rdata_r;
    assign gw_clk_en  = clken_r;
    assign group_busy = busy_r;
    assign recording  = rec_on_r;
endmodule

// [logic/ghu_pkg.sv]
// Purpose: Shared constants and types of the grouped register update block
// Assumes: Byte wide register port with 16-bit addresses
// Notes:   Each recorded entry takes one 4-byte buffer word
package ghu_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_GRP0_START = 16'h3200;
    localparam logic [15:0] ADDR_GRP1_START = 16'h3201;
    localparam logic [15:0] ADDR_GRP2_START = 16'h3202;
    localparam logic [15:0] ADDR_GRP3_START = 16'h3203;
    localparam logic [15:0] ADDR_EMB_START  = 16'h3204;
    localparam logic [15:0] ADDR_FSIN_GRP   = 16'h3206;
    localparam logic [15:0] ADDR_CMB_LAUNCH = 16'h3207;
    localparam logic [15:0] ADDR_GRP_CMD    = 16'h3208;
    localparam logic [15:0] ADDR_GRP0_PER   = 16'h3209;
    localparam logic [15:0] ADDR_GRP1_PER   = 16'h320a;
    localparam logic [15:0] ADDR_GRP2_PER   = 16'h320b;
    localparam logic [15:0] ADDR_GRP3_PER   = 16'h320c;
    localparam logic [15:0] ADDR_SW_CTRL    = 16'h320d;
    localparam logic [11:0] ADDR_CTL_PAGE   = 12'h320;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_GRP0_START = 8'h00;
    localparam logic [7:0] RST_GRP1_START = 8'h08;
    localparam logic [7:0] RST_GRP2_START = 8'h10;
    localparam logic [7:0] RST_GRP3_START = 8'h18;
    localparam logic [7:0] RST_EMB_START  = 8'h20;
    localparam logic [7:0] RST_FSIN_GRP   = 8'h10;
    localparam logic [7:0] RST_PERIOD     = 8'h00;
    localparam logic [7:0] RST_SW_CTRL    = 8'h01;

    // ------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------
    localparam int          BUF_BYTES  = 1536;
    localparam int          BUF_WORDS  = 384;
    localparam logic [8:0]  BUF_END_W  = 9'h180;
    localparam int          REC_GROUPS = 4;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int         SW_REPEAT_BIT = 5;
    localparam int         SW_CTX_BIT    = 4;
    localparam int         FSIN_EN_BIT   = 4;
    localparam logic [1:0] SW_AUTO_ON    = 2'h3;
    localparam logic [3:0] CMD_REC_START = 4'h0;
    localparam logic [3:0] CMD_REC_END   = 4'h1;
    localparam logic [3:0] CMD_LAUNCH    = 4'ha;
    localparam logic [3:0] CMD_FAST      = 4'he;
    localparam logic [3:0] CMB_FRAME     = 4'ha;
    localparam logic [3:0] CMB_NOW       = 4'he;
    localparam logic [3:0] CMB_HBLANK    = 4'h6;

    typedef enum logic [1:0] {
        GHU_ST_IDLE  = 2'b00,
        GHU_ST_READ  = 2'b01,
        GHU_ST_WRITE = 2'b10
    } ghu_state_t;

    typedef enum logic [1:0] {
        GHU_TM_FRAME  = 2'b00,
        GHU_TM_NOW    = 2'b01,
        GHU_TM_HBLANK = 2'b10
    } ghu_timing_t;
endpackage

// [logic/ghu_buf_if.sv]
// Purpose: Carrier between the update controller and the group buffer
// Assumes: One write and one registered read port
// Notes:   Read data appears one clock after the read address
interface ghu_buf_if;
    logic        wr;
    logic [8:0]  waddr;
    logic [23:0] wdata;
    logic [8:0]  raddr;
    logic [23:0] rdata;

    modport ctrl (output wr, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface

// [logic/ghu_buffer.sv]
// Purpose: Shared group buffer holding recorded address and value entries
// Assumes: 1536 bytes held as 384 words of one entry each
// Notes:   Contents are not reset
module ghu_buffer (
    input  wire logic mclk,
    ghu_buf_if.mem    bus
);
    logic [23:0] mem_r [0:ghu_pkg::BUF_WORDS-1];
    logic [23:0] rdata_r;

    always_ff @(posedge mclk) begin
        if (bus.wr) begin
            mem_r[bus.waddr] <= bus.wdata;
        end
        rdata_r <= mem_r[bus.raddr];
    end

    assign bus.rdata = rdata_r;
endmodule

// [logic/ghu_frame_cnt.sv]
// Purpose: Counts frame latch points spent in the current group
// Assumes: tick is a one-cycle pulse per frame
// Notes:   done fires on the tick that completes the period
module ghu_frame_cnt (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       tick,
    input  wire logic [7:0] period,
    output logic            done
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [8:0] cnt_inc;

    always_comb begin
        cnt_inc = {1'b0, cnt_r} + 9'h001;
        done    = tick && (cnt_inc >= {1'b0, period});
        cnt_nxt = cnt_r;
        if (clear || done) begin
            cnt_nxt = 8'h00;
        end else if (tick) begin
            cnt_nxt = cnt_inc[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// [test/ghu_group_update_asserts.sv]
// Purpose: Port checks of the grouped update block
// Assumes: Inputs settle away from the rising edge
// Notes:   Attached by the bind below
module ghu_group_update_asserts (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        clk_always_on,
    input wire logic        soft_reset,
    input wire logic [7:0]  reg_rdata,
    input wire logic        tgt_wr,
    input wire logic        gw_clk_en,
    input wire logic        group_busy,
    input wire logic        recording
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    wire cmd_wr = reg_wr && reg_addr == 16'h3208 && !soft_reset;
    sequence s_fast;
        cmd_wr && reg_wdata == 8'he1 && !group_busy ##1 group_busy;
    endsequence
    AST_REC_START: assert property (cmd_wr && reg_wdata == 8'h00 |=> recording) else $error("rec");
    AST_RESERVED: assert property (cmd_wr && reg_wdata[3:0] > 4'h3 |=> $stable(recording)) else $error("rsv");
    AST_FAST: assert property (s_fast |-> ##3 tgt_wr) else $error("fast");
    AST_TGT_PULSE: assert property (tgt_wr |=> !tgt_wr) else $error("pulse");
    AST_TGT_BUSY: assert property (tgt_wr |-> $past(group_busy, 2)) else $error("busy");
    AST_WO_READ: assert property (reg_rd && (reg_addr == 16'h3207 || reg_addr == 16'h3208)
        |=> reg_rdata == 8'h00) else $error("wo");
    AST_CLK_ON: assert property (clk_always_on |=> gw_clk_en) else $error("clk");
    AST_SOFT: assert property (soft_reset |=> !group_busy && !recording) else $error("soft");
endmodule
bind ghu_group_update ghu_group_update_asserts ghu_group_update_asserts_inst (.mclk, .reset,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .clk_always_on, .soft_reset, .reg_rdata,
    .tgt_wr, .gw_clk_en, .group_busy, .recording);

// [test/ghu_group_update_test.sv]
// Purpose: Self-checking bench of the grouped update block
// Assumes: Inputs change on the falling edge
// Notes:   Expected entries kept in a queue
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module ghu_group_update_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        soft_reset = 1'b0, hblank = 1'b0, vblank = 1'b0, tgt_wr, gw_clk_en;
    logic        group_busy, recording;
    logic [15:0] reg_addr = 16'h0000, tgt_addr;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, tgt_data, v;
    logic [23:0] exp_q[$], got_q[$], mdl_q[$], e0;
    logic        clk_always_on = 1'b1, long_vblank = 1'b0, frame_latch = 1'b0, fsin_pulse = 1'b0;
    int          per[2] = '{1, 2}, cur = 0, cnt = 0;
    logic [23:0] rst_tab[13] = '{24'h320000, 24'h320108, 24'h320210, 24'h320318, 24'h320420,
        24'h320500, 24'h320610, 24'h320800, 24'h320900, 24'h320a00, 24'h320b00, 24'h320c00,
        24'h320d01};
    int          fails = 0, total_checks = 0, seed = 58319;
    ghu_group_update ghu_group_update_inst (.mclk, .reset, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .clk_always_on, .soft_reset, .frame_latch, .hblank, .vblank,
        .long_vblank, .fsin_pulse, .reg_rdata, .tgt_wr, .tgt_addr, .tgt_data,
        .gw_clk_en, .group_busy, .recording);
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (tgt_wr === 1'b1) got_q.push_back({tgt_addr, tgt_data});
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge mclk) reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge mclk) reg_rd = 1'b0;
        `CHK(reg_rdata, e)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        foreach (rst_tab[i]) rd(rst_tab[i][23:8], rst_tab[i][7:0]);
        $display("test reset done");
        wr(16'h3208, 8'h01);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            wr(16'h3500 + 16'(i), v);
            exp_q.push_back({16'h3500 + 16'(i), v});
        end
        wr(16'h3208, 8'h11);
        wr(16'h3208, 8'h05);
        wr(16'h3208, 8'h21);
        `CHK(recording, 1'b0)
        $display("test record done");
        for (int m = 0; m < 3; m++) begin
            got_q.delete();
            wr(m == 2 ? 16'h3207 : 16'h3208, m == 0 ? 8'he1 : m == 1 ? 8'ha1 : 8'h62);
            repeat (12) @(negedge mclk);
            `CHK(got_q.size(), m == 0 ? 3 : 0)
            {vblank, hblank} = 2'b11;
            repeat (12) @(negedge mclk);
            {vblank, hblank} = 2'b00;
            foreach (exp_q[k]) `CHK(got_q[k], exp_q[k])
            `CHK(group_busy, 1'b0)
            $display("test launch %0d done", m);
        end
        wr(16'h3208, 8'h02);
        `CHK(recording, 1'b1)
        soft_reset = 1'b1;
        @(negedge mclk) soft_reset = 1'b0;
        `CHK(recording, 1'b0)
        $display("test soft reset done");
        wr(16'h3208, 8'h00);
        e0 = {16'h3600, 8'($random(seed))};
        wr(e0[23:8], e0[7:0]);
        wr(16'h3208, 8'h10);
        wr(16'h3209, 8'h01);
        wr(16'h320a, 8'h02);
        wr(16'h320b, 8'h00);
        wr(16'h320c, 8'h00);
        got_q.delete();
        vblank = 1'b1;
        wr(16'h320d, 8'h31);
        wr(16'h3208, 8'ha0);
        mdl_q.push_back(e0);
        for (int f = 0; f < 3; f++) begin
            repeat (10) @(negedge mclk);
            `CHK(got_q.size(), mdl_q.size())
            frame_latch = 1'b1;
            @(negedge mclk) frame_latch = 1'b0;
            if (++cnt >= per[cur]) begin
                cur = 1 - cur;
                cnt = 0;
                if (cur == 0) mdl_q.push_back(e0);
                else foreach (exp_q[k]) mdl_q.push_back(exp_q[k]);
            end
        end
        repeat (10) @(negedge mclk);
        `CHK(got_q.size(), mdl_q.size())
        foreach (mdl_q[k]) `CHK(got_q[k], mdl_q[k])
        soft_reset = 1'b1;
        @(negedge mclk) soft_reset = 1'b0;
        `CHK(group_busy, 1'b0)
        $display("test auto switch done");
        // frame sync launch, latch ignored once stopped
        got_q.delete();
        {fsin_pulse, frame_latch} = 2'b11;
        @(negedge mclk) {fsin_pulse, frame_latch} = 2'b00;
        repeat (10) @(negedge mclk);
        `CHK(got_q.size(), 1)
        `CHK(got_q[0], e0)
        $display("test frame sync done");
        {clk_always_on, long_vblank, vblank} = 3'b010;
        @(negedge mclk) `CHK(gw_clk_en, 1'b0)
        clk_always_on = 1'b1;
        @(negedge mclk) `CHK(gw_clk_en, 1'b1)
        $display("test gating done");
        finish_test;
    end
    initial begin
        #100000 fails++;
        finish_test;
    end
endmodule
